// file: core/frame_classifier.sv
// classifies and checks a frame; combinational verdict
module frame_classifier (
   frame_if.dst          fr,
   input  wire logic     nak_on_err_i,
   output logic          fmt_bad_o,
   output logic          nak1_o
);
   logic is_rd;
   logic is_wr;
   always_comb begin
      is_rd     = fr.cmd == tag_err_pkg::CMD_READ;
      is_wr     = fr.cmd == tag_err_pkg::CMD_WRITE;
      fmt_bad_o = 1'b0;
      nak1_o    = 1'b0;
      if (fr.code_err || fr.incomplete || fr.len == 5'h0_0) begin
         fmt_bad_o = 1'b1;
      end else if (fr.par_err || fr.crc_err) begin
         fmt_bad_o = !nak_on_err_i;
         nak1_o    = nak_on_err_i;
      end else if (!fr.has_crc && fr.len == 5'h0_1) begin
         fmt_bad_o = 1'b1;
      end else if (is_wr && fr.len == 5'h0_2) begin
         fmt_bad_o = 1'b1;
      end else if (is_wr && fr.len != 5'(tag_err_pkg::WRITE_LEN)) begin
         fmt_bad_o = 1'b1;
      end else if (is_rd && fr.len != 5'(tag_err_pkg::READ_LEN)) begin
         fmt_bad_o = 1'b1;
      end else if (!fr.has_crc) begin
         fmt_bad_o = 1'b1;
      end
   end
endmodule

// file: core/frame_if.sv
interface frame_if;
   logic       valid;
   logic [7:0] cmd;
   logic [7:0] addr;
   logic [4:0] len;
   logic       has_crc;
   logic       crc_err;
   logic       par_err;
   logic       code_err;
   logic       incomplete;
   modport src (output valid, cmd, addr, len, has_crc, crc_err, par_err, code_err, incomplete);
   modport dst (input  valid, cmd, addr, len, has_crc, crc_err, par_err, code_err, incomplete);
endinterface

// file: core/tag_err_pkg.sv
package tag_err_pkg;
   // reply kinds
   typedef enum logic [2:0] {
      REPLY_NONE,
      REPLY_ACK,
      REPLY_NAK,
      REPLY_DATA
   } reply_kind_e;

   localparam logic [3:0] NAK_ADDR    = 4'h0;
   localparam logic [3:0] NAK_CRC     = 4'h1;
   localparam logic [3:0] NAK_PROT    = 4'h4;
   localparam logic [3:0] NAK_COLL    = 4'h5;

   localparam logic [7:0] CMD_READ    = 8'h30;
   localparam logic [7:0] CMD_WRITE   = 8'hA2;
   localparam logic [7:0] BUF_FIRST   = 8'hFC;
   localparam logic [7:0] BUF_LAST    = 8'hFF;

   // frame lengths in bytes, without CRC; then block and read sizes in bytes, and the length field width
   localparam int unsigned READ_LEN   = 2;
   localparam int unsigned WRITE_LEN  = 6;
   localparam int unsigned BLOCK_BYTES = 4;
   localparam int unsigned READ_BYTES = 16;
   localparam int unsigned LEN_W      = 5;
endpackage

// file: core/tag_rf_command_error_handler.sv
// Function
// - malformed frame: silent, then sleep
// - parity/CRC error: silent or NAK1, sleep
// - one byte without CRC: silent, sleep
// - two-byte write with CRC: silent, sleep
// - wrong-length read or write: silent, sleep
// - protected bytes read zero; fully protected NAK4
// - wholly absent address range: NAK0, sleep
// - partly absent read range padded with zeros
// - interleaved EEPROM write completes, buffer discarded
// - status flags readable at any time
// - status shows reader busy, reader ready, host ready
// - rx start, rx end, tx end events
// - buffer write not starting at first block: NAK0
// - buffer write while data ready: NAK0
module tag_rf_command_error_handler #(
   parameter int unsigned MEM_BLOCKS = 64
) (
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        frame_valid_i,
   input  wire logic [7:0]  frame_cmd_i,
   input  wire logic [7:0]  frame_addr_i,
   input  wire logic [4:0]  frame_len_i,
   input  wire logic        frame_has_crc_i,
   input  wire logic        frame_crc_err_i,
   input  wire logic        frame_par_err_i,
   input  wire logic        frame_code_err_i,
   input  wire logic        frame_incomplete_i,
   input  wire logic        nak_on_err_i,
   input  wire logic        tunnel_mode_i,
   input  wire logic [63:0] block_prot_i,
   input  wire logic        host_ee_busy_i,
   input  wire logic        host_data_ready_i,
   input  wire logic        host_clear_i,
   output logic             reply_valid_o,
   output logic [2:0]       reply_kind_o,
   output logic [3:0]       reply_nak_o,
   output logic [15:0]      byte_keep_o,
   output logic             sleep_o,
   output logic             ee_write_o,
   output logic             buf_write_o,
   output logic             buf_discard_o,
   output logic             reader_side_busy_flag_o,
   output logic             reader_data_ready_flag_o,
   output logic             host_data_ready_flag_o,
   output logic             rx_start_o,
   output logic             rx_end_o,
   output logic             tx_end_o
);
   frame_if fr ();
   assign fr.valid      = frame_valid_i;
   assign fr.cmd        = frame_cmd_i;
   assign fr.addr       = frame_addr_i;
   assign fr.len        = frame_len_i;
   assign fr.has_crc    = frame_has_crc_i;
   assign fr.crc_err    = frame_crc_err_i;
   assign fr.par_err    = frame_par_err_i;
   assign fr.code_err   = frame_code_err_i;
   assign fr.incomplete = frame_incomplete_i;

   logic fmt_bad;
   logic nak1;
   frame_classifier u_cls (
      .fr           (fr),
      .nak_on_err_i (nak_on_err_i),
      .fmt_bad_o    (fmt_bad),
      .nak1_o       (nak1)
   );

   function automatic logic in_mem(input logic [7:0] blk);
      in_mem = 32'(blk) < MEM_BLOCKS;
   endfunction

   function automatic logic is_prot(input logic [7:0] blk);
      is_prot = in_mem(blk) && block_prot_i[blk[5:0]];
   endfunction

   logic          busy_q;
   logic          rdy_q;
   tag_err_pkg::reply_kind_e kind_d;
   logic [3:0]    nak_d;
   logic [15:0]   keep_d;
   logic          is_rd;
   logic          is_wr;
   logic          is_buf;
   logic          do_ee_wr;
   logic          do_buf_wr;
   logic [7:0]    blk;

   always_comb begin
      is_rd     = frame_cmd_i == tag_err_pkg::CMD_READ;
      is_wr     = frame_cmd_i == tag_err_pkg::CMD_WRITE;
      is_buf    = tunnel_mode_i && frame_addr_i >= tag_err_pkg::BUF_FIRST;
      kind_d    = tag_err_pkg::REPLY_NONE;
      nak_d     = tag_err_pkg::NAK_ADDR;
      keep_d    = 16'h0000;
      do_ee_wr  = 1'b0;
      do_buf_wr = 1'b0;
      blk       = 8'h00;
      if (nak1) begin
         kind_d = tag_err_pkg::REPLY_NAK;
         nak_d  = tag_err_pkg::NAK_CRC;
      end else if (fmt_bad || !(is_rd || is_wr)) begin
         kind_d = tag_err_pkg::REPLY_NONE;
      end else if (host_ee_busy_i && !is_buf) begin
         kind_d = tag_err_pkg::REPLY_NAK;
         nak_d  = tag_err_pkg::NAK_COLL;
      end else if (is_buf && is_wr) begin
         if (frame_addr_i != tag_err_pkg::BUF_FIRST && !busy_q) begin
            kind_d = tag_err_pkg::REPLY_NAK;
         end else if (rdy_q || host_data_ready_i) begin
            kind_d = tag_err_pkg::REPLY_NAK;
         end else begin
            kind_d    = tag_err_pkg::REPLY_ACK;
            do_buf_wr = 1'b1;
         end
      end else if (is_buf && is_rd) begin
         kind_d = tag_err_pkg::REPLY_DATA;
         keep_d = 16'hFFFF;
      end else if (!in_mem(frame_addr_i)) begin
         kind_d = tag_err_pkg::REPLY_NAK;
      end else if (is_prot(frame_addr_i) && (is_wr || (is_prot(frame_addr_i + 8'h01)
               && is_prot(frame_addr_i + 8'h02) && is_prot(frame_addr_i + 8'h03)))) begin
         kind_d = tag_err_pkg::REPLY_NAK;
         nak_d  = tag_err_pkg::NAK_PROT;
      end else if (is_wr) begin
         kind_d   = tag_err_pkg::REPLY_ACK;
         do_ee_wr = 1'b1;
      end else begin
         kind_d = tag_err_pkg::REPLY_DATA;
         for (int i = 0; i < 4; i++) begin
            blk = frame_addr_i + 8'(i);
            keep_d[4*i +: 4] = (in_mem(blk) && !is_prot(blk)) ? 4'hF : 4'h0;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         reply_valid_o <= 1'b0;
         reply_kind_o  <= 3'h0;
         reply_nak_o   <= 4'h0;
         byte_keep_o   <= 16'h0000;
         sleep_o       <= 1'b0;
         ee_write_o    <= 1'b0;
         buf_write_o   <= 1'b0;
      end else begin
         reply_valid_o <= frame_valid_i;
         reply_kind_o  <= kind_d;
         reply_nak_o   <= nak_d;
         byte_keep_o   <= keep_d;
         sleep_o       <= frame_valid_i && (kind_d == tag_err_pkg::REPLY_NONE
                                         || kind_d == tag_err_pkg::REPLY_NAK);
         ee_write_o    <= frame_valid_i && do_ee_wr;
         buf_write_o   <= frame_valid_i && do_buf_wr;
      end
   end

   // tunnelling buffer handshake flags
   logic disc_d;
   assign disc_d = frame_valid_i && do_ee_wr && busy_q;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         busy_q        <= 1'b0;
         rdy_q         <= 1'b0;
         rx_start_o    <= 1'b0;
         rx_end_o      <= 1'b0;
         tx_end_o      <= 1'b0;
         buf_discard_o <= 1'b0;
      end else begin
         rx_start_o    <= 1'b0;
         rx_end_o      <= 1'b0;
         tx_end_o      <= 1'b0;
         buf_discard_o <= disc_d;
         if (disc_d) begin
            busy_q <= 1'b0;
         end else if (frame_valid_i && do_buf_wr) begin
            if (frame_addr_i == tag_err_pkg::BUF_FIRST) begin
               busy_q     <= 1'b1;
               rx_start_o <= 1'b1;
            end
            if (frame_addr_i == tag_err_pkg::BUF_LAST) begin
               busy_q   <= 1'b0;
               rdy_q    <= 1'b1;
               rx_end_o <= 1'b1;
            end
         end
         if (host_clear_i && !(frame_valid_i && do_buf_wr && frame_addr_i == tag_err_pkg::BUF_LAST)) begin
            rdy_q <= 1'b0;
         end
         if (frame_valid_i && is_buf && is_rd && host_data_ready_i) begin
            tx_end_o <= 1'b1;
         end
      end
   end

   assign reader_side_busy_flag_o  = busy_q;
   assign reader_data_ready_flag_o = rdy_q;
   assign host_data_ready_flag_o   = host_data_ready_i;

   sequence bad_frame_s;
      frame_valid_i && frame_code_err_i;
   endsequence
   sequence silent_sleep_s;
      sleep_o && reply_kind_o == 3'(tag_err_pkg::REPLY_NONE);
   endsequence

   code_err_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      bad_frame_s |=> silent_sleep_s) else $error("malformed frame not silent");
   crc_nak_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      frame_valid_i && !frame_code_err_i && !frame_incomplete_i && frame_len_i != 5'h0_0
      && frame_crc_err_i && nak_on_err_i |=> reply_nak_o == 4'h1 && sleep_o)
      else $error("crc error without nak1");
   one_byte_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      frame_valid_i && !frame_crc_err_i && !frame_par_err_i && !frame_has_crc_i && frame_len_i == 5'h0_1
      |=> silent_sleep_s) else $error("one byte frame answered");
   short_wr_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      frame_valid_i && !frame_crc_err_i && !frame_par_err_i && !frame_code_err_i && !frame_incomplete_i
      && frame_cmd_i == 8'hA2 && frame_len_i == 5'h0_2 |=> silent_sleep_s) else $error("two byte write answered");
   range_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      reply_valid_o && reply_kind_o == 3'(tag_err_pkg::REPLY_NAK) && reply_nak_o == 4'h0 |-> sleep_o)
      else $error("nak0 without sleep");
   ack_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      reply_valid_o && reply_kind_o == 3'(tag_err_pkg::REPLY_ACK) |-> !sleep_o) else $error("ack with sleep");
   flags_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      frame_valid_i && !nak1 && !fmt_bad && !host_ee_busy_i && is_buf && is_wr && (rdy_q || host_data_ready_i)
      |=> reply_kind_o == 3'(tag_err_pkg::REPLY_NAK) && reply_nak_o == tag_err_pkg::NAK_ADDR && sleep_o
      && !buf_write_o) else $error("buffer write while ready");
   discard_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      disc_d |=> buf_discard_o && ee_write_o && !busy_q) else $error("interleaved write mishandled");
endmodule

// file: verification/reader_model.sv
module reader_model (
   input  wire logic mclk_i,
   frame_if.src      fr
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {fr.valid, fr.cmd, fr.addr, fr.len, fr.has_crc, fr.crc_err, fr.par_err, fr.code_err, fr.incomplete} = '0;
   // eeprom writes follow a drained buffer and a clear busy read, unless the bench interleaves on purpose
   task automatic send(input logic [7:0] c, a, input logic [4:0] l, f);
      @(posedge mclk_i);
      #1;
      fr.valid = 1'b1;
      fr.cmd = c;
      fr.addr = a;
      fr.len = l;
      {fr.has_crc, fr.crc_err, fr.par_err, fr.code_err, fr.incomplete} = f;
      @(posedge mclk_i);
      #1;
      // released lines carry the inverse, never the stale value
      fr.valid = 1'b0;
      fr.cmd = ~c;
      fr.addr = ~a;
      fr.len = ~l;
      {fr.has_crc, fr.crc_err, fr.par_err, fr.code_err, fr.incomplete} = ~f;
   endtask
endmodule

// file: verification/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [2:0] KN = tag_err_pkg::REPLY_NONE;
   localparam logic [2:0] KA = tag_err_pkg::REPLY_ACK;
   localparam logic [2:0] KK = tag_err_pkg::REPLY_NAK;
   localparam logic [2:0] KD = tag_err_pkg::REPLY_DATA;
   localparam logic [7:0] RD = tag_err_pkg::CMD_READ;
   localparam logic [7:0] WR = tag_err_pkg::CMD_WRITE;
   localparam logic [4:0] OK = 5'h10;
   logic        mclk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        nak_on_err_i = 1'b0, tunnel_mode_i = 1'b0, host_ee_busy_i = 1'b0;
   logic        host_data_ready_i = 1'b0, host_clear_i = 1'b0;
   logic [63:0] block_prot_i = '0;
   logic        reply_valid_o, sleep_o, reader_side_busy_flag_o, reader_data_ready_flag_o, host_data_ready_flag_o;
   logic        ee_write_o, buf_write_o, buf_discard_o, rx_start_o, rx_end_o, tx_end_o;
   logic [2:0]  reply_kind_o;
   logic [3:0]  reply_nak_o;
   logic [15:0] byte_keep_o;
   logic [23:0] exp_q[$];
   logic [23:0] got;
   logic [7:0]  a;
   int          n_mismatch = 0;
   int          tests_run = 0;
   integer      seed = 32'h52a2_ba16;
   frame_if fr();
   always #5 mclk_i = ~mclk_i;
   reader_model i_reader_model (.mclk_i, .fr);
   tag_rf_command_error_handler #(.MEM_BLOCKS(64)) i_tag_rf_command_error_handler (
      .mclk_i, .sys_rst_i, .frame_valid_i(fr.valid), .frame_cmd_i(fr.cmd), .frame_addr_i(fr.addr),
      .frame_len_i(fr.len), .frame_has_crc_i(fr.has_crc), .frame_crc_err_i(fr.crc_err),
      .frame_par_err_i(fr.par_err), .frame_code_err_i(fr.code_err), .frame_incomplete_i(fr.incomplete),
      .nak_on_err_i, .tunnel_mode_i, .block_prot_i, .host_ee_busy_i, .host_data_ready_i, .host_clear_i,
      .reply_valid_o, .reply_kind_o, .reply_nak_o, .byte_keep_o, .sleep_o, .ee_write_o, .buf_write_o,
      .buf_discard_o, .reader_side_busy_flag_o, .reader_data_ready_flag_o, .host_data_ready_flag_o,
      .rx_start_o, .rx_end_o, .tx_end_o);
   task automatic chk(input logic [23:0] g, e);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic flg(input logic g, e);
      chk({23'h0, g}, {23'h0, e});
   endtask
   task automatic req(input logic [7:0] c, ad, input logic [4:0] l, f, input logic [2:0] k,
                      input logic [3:0] n, input logic s, input logic [15:0] kp);
      exp_q.push_back({k, n, s, kp});
      i_reader_model.send(c, ad, l, f);
   endtask
   task automatic none(input logic [7:0] c, input logic [4:0] l, f);
      req(c, 8'h0A, l, f, KN, 4'h0, 1'b1, 16'h0000);
   endtask
   task automatic nak(input logic [7:0] c, ad, input logic [3:0] n);
      req(c, ad, c == RD ? 5'd2 : 5'd6, OK, KK, n, 1'b1, 16'h0000);
   endtask
   task automatic good(input logic [7:0] c, ad, input logic [15:0] kp);
      req(c, ad, c == RD ? 5'd2 : 5'd6, OK, c == RD ? KD : KA, 4'h0, 1'b0, c == RD ? kp : 16'h0000);
   endtask
   task automatic test_done();
      $display("compares %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // verdict watcher: oldest note against each reply
   always @(negedge mclk_i) begin
      if (reply_valid_o === 1'b1) begin
         got = {reply_kind_o, reply_nak_o, sleep_o, (reply_kind_o === KD) ? byte_keep_o : 16'h0000};
         if (exp_q.size() > 0) chk(got, exp_q.pop_front());
         else chk(got, 24'hFF_FFFF);
      end
   end
   initial begin
      repeat (6) @(posedge mclk_i);
      #1;
      sys_rst_i = 1'b0;
      none(RD, 5'd2, 5'h12);
      none(WR, 5'd6, 5'h11);
      none(WR, 5'd0, OK);
      none(RD, 5'd1, 5'h00);
      none(WR, 5'd2, OK);
      none(WR, 5'd1, OK);
      none(WR, 5'd5, OK);
      none(WR, 5'd7, OK);
      none(RD, 5'd1, OK);
      none(RD, 5'd3, OK);
      $display("test format done");
      for (int i = 0; i < 8; i++) begin
         nak_on_err_i = i[2];
         req(i[1] ? RD : WR, 8'h0A, i[1] ? 5'd2 : 5'd6, i[0] ? 5'h18 : 5'h14, i[2] ? KK : KN,
             i[2] ? tag_err_pkg::NAK_CRC : 4'h0, 1'b1, 16'h0000);
      end
      $display("test crc done");
      good(RD, 8'd62, 16'h00FF);
      good(RD, 8'd63, 16'h000F);
      nak(RD, 8'd64, tag_err_pkg::NAK_ADDR);
      nak(WR, 8'd64, tag_err_pkg::NAK_ADDR);
      flg(ee_write_o, 1'b0);
      good(WR, 8'd63, 16'h0000);
      flg(ee_write_o, 1'b1);
      block_prot_i = 64'h0000_0000_00F0_0000;
      nak(RD, 8'd20, tag_err_pkg::NAK_PROT);
      nak(WR, 8'd21, tag_err_pkg::NAK_PROT);
      good(RD, 8'd18, 16'h00FF);
      good(RD, 8'd17, 16'h0FFF);
      block_prot_i = '0;
      $display("test memory done");
      host_ee_busy_i = 1'b1;
      nak(RD, 8'h0A, tag_err_pkg::NAK_COLL);
      nak(WR, 8'h0A, tag_err_pkg::NAK_COLL);
      host_ee_busy_i = 1'b0;
      $display("test collision done");
      tunnel_mode_i = 1'b1;
      nak(WR, 8'hFD, tag_err_pkg::NAK_ADDR);
      good(WR, 8'hFC, 16'h0000);
      flg(reader_side_busy_flag_o, 1'b1);
      flg(rx_start_o, 1'b1);
      flg(buf_write_o, 1'b1);
      good(WR, 8'hFF, 16'h0000);
      flg(reader_data_ready_flag_o, 1'b1);
      flg(rx_end_o, 1'b1);
      nak(WR, 8'hFC, tag_err_pkg::NAK_ADDR);
      good(RD, 8'hFC, 16'hFFFF);
      host_clear_i = 1'b1;
      @(posedge mclk_i);
      #1;
      host_clear_i = 1'b0;
      flg(reader_data_ready_flag_o, 1'b0);
      good(WR, 8'hFC, 16'h0000);
      good(WR, 8'h0A, 16'h0000);
      flg(reader_side_busy_flag_o, 1'b0);
      flg(buf_discard_o, 1'b1);
      flg(ee_write_o, 1'b1);
      host_data_ready_i = 1'b1;
      #1;
      flg(host_data_ready_flag_o, 1'b1);
      good(RD, 8'hFC, 16'hFFFF);
      flg(tx_end_o, 1'b1);
      nak(WR, 8'hFC, tag_err_pkg::NAK_ADDR);
      host_data_ready_i = 1'b0;
      tunnel_mode_i = 1'b0;
      $display("test tunnel done");
      for (int i = 0; i < 6; i++) begin
         a = 8'd32 + 8'($unsigned($random(seed)) % 28);
         good(i[0] ? RD : WR, a, 16'hFFFF);
      end
      $display("test random done");
      for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge mclk_i);
      if (exp_q.size() > 0) n_mismatch++;
      test_done();
   end
endmodule
